/* common/ebp_pkg.sv */
package ebp_pkg;
  // Pin widths
  localparam int DATA_W = 16;
  localparam int LADDR_W = 16;
  localparam int HADDR_W = 7;
  localparam int ADDR_W = LADDR_W + HADDR_W;
  // Register map (byte addresses)
  localparam logic [11:0] OFS_BANK_SWITCH = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [31:0] BANK_SWITCH_RST = 32'h0000_0000;
  // Field positions
  localparam int KEEP_EN_BIT = 1;
  localparam int STAT_HOLD_ACK_BIT = 0;
  localparam int STAT_HOST_MODE_BIT = 1;
  localparam int STAT_DRIVING_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_KEEPING_BIT = 4;
  // Data phase length of an external access, in clock cycles
  localparam int ACCESS_CYCLES_DEF = 2;

  typedef enum logic [1:0]
  {
    SP_PROG = 2'b00,
    SP_DATA = 2'b01,
    SP_IO = 2'b10
  } ebp_space_e;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_XFER = 2'b11,
    ST_HOLD = 2'b10
  } ebp_state_e;

  typedef struct packed
  {
    logic valid;
    ebp_space_e space;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebp_req_s;

  typedef struct packed
  {
    logic done;
    logic [DATA_W-1:0] rdata;
  } ebp_rsp_s;

  typedef struct packed
  {
    logic drive;
    logic [DATA_W-1:0] rdata;
  } ebp_host_s;
endpackage

/* src/ebp_keeper.sv */
`timescale 1ns/1ps
module ebp_keeper
#(
  parameter int W = 16
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Next driver state and enable
  input wire logic [W-1:0] drv_val_nxt_in,
  input wire logic drv_oe_nxt_in,
  input wire logic keep_en_in,
  // Holder drive
  output logic [W-1:0] keep_val_out,
  output logic keep_oe_out
);
  generate
    if (W < 1)
    begin : g_chk
      $error("ebp_keeper: W must be at least 1");
    end
  endgenerate

  // Follows the driver's next state so the holder takes over in the same
  // edge the driver lets go; no floating cycle in between
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
          keep_val_out[i] <= 1'b0;
        else if (drv_oe_nxt_in)
          keep_val_out[i] <= drv_val_nxt_in[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      keep_oe_out <= 1'b0;
    else
      keep_oe_out <= keep_en_in & ~drv_oe_nxt_in;
  end
endmodule // ebp_keeper

/* src/ebp_apb_regs.sv */
`timescale 1ns/1ps
module ebp_apb_regs
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block side
  input wire logic pin_reset_in,
  input wire logic [31:0] status_in,
  output logic keep_en_out
);
  import ebp_pkg::*;

  logic [31:0] bank_switch_r;
  logic hit_bank;
  logic hit_stat;
  logic wr_fire;

  assign hit_bank = (paddr == OFS_BANK_SWITCH);
  assign hit_stat = (paddr == OFS_STATUS);
  assign wr_fire = psel & penable & pready & pwrite;
  assign keep_en_out = bank_switch_r[KEEP_EN_BIT];

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready)
    begin
      pslverr <= ~(hit_bank | hit_stat);
      if (pwrite | ~(hit_bank | hit_stat))
        prdata <= 32'h0000_0000;
      else if (hit_bank)
        prdata <= bank_switch_r;
      else
        prdata <= status_in;
    end
    else
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // RULE_06: holders off at reset
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bank_switch_r <= BANK_SWITCH_RST;
    else if (pin_reset_in)
      bank_switch_r <= BANK_SWITCH_RST;
    else if (wr_fire & hit_bank)
      bank_switch_r <= {30'h0000_0000, pwdata[KEEP_EN_BIT], 1'b0};
  end
endmodule // ebp_apb_regs

/* src/ebp_pin_ctrl.sv */
// Summary of operation
// RULE_01: With the wide host mode pin high the low address pins are inputs for the host port.
// RULE_02: The data pins carry words for core accesses or for the host port in wide mode.
// RULE_03: Data pins are undriven when not outputting and while reset or hold is asserted.
// RULE_04: Data pins are undriven whenever the output-off pin is low.
// RULE_05: With holders on and the driver off, each data pin keeps its last driven level.
// RULE_06: Holders are off after reset and software switches them via the bank switch register.
// RULE_07: Low address pins serve every space; high address pins only program space.
// RULE_08: Address pins are undriven in hold mode or while the output-off pin is low.
// RULE_09: An outside master asserts hold and, once acknowledged, gets the lines released.
// RULE_10: A per-bit holder register takes each driven value and shows it only when undriven.
`timescale 1ns/1ps
module ebp_pin_ctrl
#(
  parameter int ACCESS_CYCLES = ebp_pkg::ACCESS_CYCLES_DEF
)
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // APB register port
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Core access side
  input wire ebp_pkg::ebp_req_s CORE_REQ_IN,
  output ebp_pkg::ebp_rsp_s CORE_RSP_OUT,
  // Host port side
  input wire ebp_pkg::ebp_host_s HOST_IN,
  output logic [ebp_pkg::LADDR_W-1:0] HOST_ADDR_OUT,
  output logic [ebp_pkg::DATA_W-1:0] HOST_WDATA_OUT,
  // Control pins
  input wire logic HOST_WIDE_MODE_SELECT_IN,
  input wire logic RESET_INPUT_N_IN,
  input wire logic HOLD_REQ_N_IN,
  input wire logic OUTPUT_OFF_N_IN,
  output logic HOLD_ACK_N_OUT,
  // Address pins
  input wire logic [ebp_pkg::LADDR_W-1:0] LOW_ADDRESS_PINS_IN,
  output logic [ebp_pkg::LADDR_W-1:0] LOW_ADDRESS_PINS_OUT,
  output logic LOW_ADDRESS_PINS_OE_OUT,
  output logic [ebp_pkg::HADDR_W-1:0] HIGH_ADDRESS_PINS_OUT,
  output logic HIGH_ADDRESS_PINS_OE_OUT,
  // Data pins and holders
  input wire logic [ebp_pkg::DATA_W-1:0] DATA_PINS_IN,
  output logic [ebp_pkg::DATA_W-1:0] DATA_PINS_OUT,
  output logic DATA_PINS_OE_OUT,
  output logic [ebp_pkg::DATA_W-1:0] DATA_KEEP_OUT,
  output logic DATA_KEEP_OE_OUT
);
  import ebp_pkg::*;

  generate
    if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255)
    begin : g_chk
      $error("ebp_pin_ctrl: ACCESS_CYCLES must be 1..255");
    end
  endgenerate

  ebp_state_e state_r;
  ebp_state_e state_nxt;
  ebp_req_s lat_r;
  logic [7:0] cnt_r;
  logic off;
  logic pin_rst;
  logic hold_req;
  logic host_mode;
  logic take;
  logic last;
  logic keep_en;
  logic data_oe_nxt;
  logic [DATA_W-1:0] data_nxt;
  logic low_oe_nxt;
  logic high_oe_nxt;
  logic [31:0] status;

  assign off = ~OUTPUT_OFF_N_IN;
  assign pin_rst = ~RESET_INPUT_N_IN;
  assign hold_req = ~HOLD_REQ_N_IN;
  assign host_mode = HOST_WIDE_MODE_SELECT_IN;
  // Done guard stops a held request from being taken twice
  assign take = CORE_REQ_IN.valid & ~host_mode & ~pin_rst & ~CORE_RSP_OUT.done;
  assign last = (cnt_r == 8'h01);

  // Host mode only blocks new accesses from idle; an access in flight ends
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        // RULE_09: grant hold only between accesses
        if (hold_req)
          state_nxt = ST_HOLD;
        else if (take)
          state_nxt = ST_ADDR;
      end
      ST_ADDR:
        state_nxt = ST_XFER;
      ST_XFER:
      begin
        if (last)
          state_nxt = ST_IDLE;
      end
      ST_HOLD:
      begin
        if (!hold_req)
          state_nxt = ST_IDLE;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    if (pin_rst)
      state_nxt = ST_IDLE;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      lat_r <= '0;
    else if (state_r == ST_IDLE && state_nxt == ST_ADDR)
      lat_r <= CORE_REQ_IN;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      cnt_r <= 8'h00;
    else if (state_nxt == ST_ADDR)
      cnt_r <= 8'(ACCESS_CYCLES);
    else if (state_r == ST_XFER && !last)
      cnt_r <= cnt_r - 8'h01;
  end

  // Read data is sampled in the last data cycle
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      CORE_RSP_OUT <= '0;
    else if (state_r == ST_XFER && last && !pin_rst)
    begin
      CORE_RSP_OUT.done <= 1'b1;
      CORE_RSP_OUT.rdata <= lat_r.write ? 16'h0000 : DATA_PINS_IN;
    end
    else
      CORE_RSP_OUT.done <= 1'b0;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      HOLD_ACK_N_OUT <= 1'b1;
    else
      HOLD_ACK_N_OUT <= ~(state_nxt == ST_HOLD);
  end

  // Address pin drivers
  always_comb
  begin
    // RULE_07: high pins only for program space
    high_oe_nxt = (state_nxt == ST_ADDR || state_nxt == ST_XFER) && lat_or_new_prog();
    low_oe_nxt = (state_nxt == ST_ADDR || state_nxt == ST_XFER) && !host_mode;
    // RULE_08: released in hold or when outputs are off
    if (off || state_nxt == ST_HOLD)
    begin
      high_oe_nxt = 1'b0;
      low_oe_nxt = 1'b0;
    end
    // RULE_01: low address pins become host inputs
    if (host_mode)
      low_oe_nxt = 1'b0;
  end

  function automatic logic lat_or_new_prog();
    if (state_r == ST_IDLE)
      return CORE_REQ_IN.space == SP_PROG;
    else
      return lat_r.space == SP_PROG;
  endfunction

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      LOW_ADDRESS_PINS_OUT <= '0;
      HIGH_ADDRESS_PINS_OUT <= '0;
    end
    else if (state_r == ST_IDLE && state_nxt == ST_ADDR)
    begin
      LOW_ADDRESS_PINS_OUT <= CORE_REQ_IN.addr[LADDR_W-1:0];
      HIGH_ADDRESS_PINS_OUT <= (CORE_REQ_IN.space == SP_PROG)
        ? CORE_REQ_IN.addr[ADDR_W-1:LADDR_W] : 7'h00;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      LOW_ADDRESS_PINS_OE_OUT <= 1'b0;
      HIGH_ADDRESS_PINS_OE_OUT <= 1'b0;
    end
    else
    begin
      LOW_ADDRESS_PINS_OE_OUT <= low_oe_nxt;
      HIGH_ADDRESS_PINS_OE_OUT <= high_oe_nxt;
    end
  end

  // Data pin driver
  always_comb
  begin
    // RULE_02: core write words or host port read words
    data_oe_nxt = 1'b0;
    data_nxt = DATA_PINS_OUT;
    if (state_nxt == ST_XFER && (state_r == ST_ADDR ? lat_r.write : lat_r.write))
    begin
      data_oe_nxt = 1'b1;
      data_nxt = lat_r.wdata;
    end
    else if (host_mode && HOST_IN.drive && state_nxt == ST_IDLE)
    begin
      data_oe_nxt = 1'b1;
      data_nxt = HOST_IN.rdata;
    end
    // RULE_03: released under reset or hold request
    // RULE_04: released when outputs are off
    if (pin_rst || hold_req || off)
      data_oe_nxt = 1'b0;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      DATA_PINS_OUT <= '0;
      DATA_PINS_OE_OUT <= 1'b0;
    end
    else
    begin
      DATA_PINS_OUT <= data_nxt;
      DATA_PINS_OE_OUT <= data_oe_nxt;
    end
  end

  // Host port capture of address and write data
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      HOST_ADDR_OUT <= '0;
      HOST_WDATA_OUT <= '0;
    end
    else if (host_mode)
    begin
      HOST_ADDR_OUT <= LOW_ADDRESS_PINS_IN;
      HOST_WDATA_OUT <= DATA_PINS_IN;
    end
  end

  // RULE_05: holder keeps last driven level
  // RULE_10: per-bit holder register
  ebp_keeper #(.W(DATA_W)) u_keeper
  (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .drv_val_nxt_in(data_nxt),
    .drv_oe_nxt_in(data_oe_nxt),
    .keep_en_in(keep_en),
    .keep_val_out(DATA_KEEP_OUT),
    .keep_oe_out(DATA_KEEP_OE_OUT)
  );

  always_comb
  begin
    status = 32'h0000_0000;
    status[STAT_HOLD_ACK_BIT] = ~HOLD_ACK_N_OUT;
    status[STAT_HOST_MODE_BIT] = host_mode;
    status[STAT_DRIVING_BIT] = DATA_PINS_OE_OUT;
    status[STAT_BUSY_BIT] = (state_r == ST_ADDR) || (state_r == ST_XFER);
    status[STAT_KEEPING_BIT] = DATA_KEEP_OE_OUT;
  end

  // RULE_06: holder enable from bank switch register
  ebp_apb_regs u_regs
  (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .psel(PSEL_IN),
    .penable(PENABLE_IN),
    .pwrite(PWRITE_IN),
    .paddr(PADDR_IN),
    .pwdata(PWDATA_IN),
    .prdata(PRDATA_OUT),
    .pready(PREADY_OUT),
    .pslverr(PSLVERR_OUT),
    .pin_reset_in(pin_rst),
    .status_in(status),
    .keep_en_out(keep_en)
  );

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  AST_HOST_ADDR_INPUT: assert property (host_mode |=> !LOW_ADDRESS_PINS_OE_OUT) // RULE_01
    else $error("low address pins driven in host mode");
  AST_WRITE_DRIVES: assert property ((state_r == ST_ADDR) && lat_r.write && !off && !pin_rst
    && !hold_req |=> DATA_PINS_OE_OUT && (DATA_PINS_OUT == $past(lat_r.wdata))) // RULE_02
    else $error("write word not driven on data pins");
  AST_DATA_RST_HOLD: assert property (pin_rst || hold_req |=> !DATA_PINS_OE_OUT) // RULE_03
    else $error("data pins driven under reset or hold");
  AST_DATA_OFF: assert property (off |=> !DATA_PINS_OE_OUT) // RULE_04
    else $error("data pins driven while outputs off");
  AST_KEEP_LAST: assert property ($fell(DATA_PINS_OE_OUT) && $past(keep_en)
    |-> DATA_KEEP_OE_OUT && (DATA_KEEP_OUT == $past(DATA_PINS_OUT))) // RULE_05
    else $error("holder lost last driven level");
  AST_KEEP_RESET: assert property (pin_rst |-> ##2 !DATA_KEEP_OE_OUT) // RULE_06
    else $error("holder still on after reset pin");
  AST_HIGH_PROG: assert property (HIGH_ADDRESS_PINS_OE_OUT |-> lat_r.space == SP_PROG) // RULE_07
    else $error("high address pins driven outside program space");
  AST_ADDR_RELEASE: assert property (off || hold_req && state_r == ST_IDLE
    |=> !LOW_ADDRESS_PINS_OE_OUT && !HIGH_ADDRESS_PINS_OE_OUT) // RULE_08
    else $error("address pins driven in hold or off");
  AST_HOLD_ACK: assert property (hold_req && state_r == ST_IDLE && !pin_rst
    |=> !HOLD_ACK_N_OUT && !DATA_PINS_OE_OUT) // RULE_09
    else $error("hold not acknowledged with lines released");
  AST_KEEP_EXCL: assert property (DATA_KEEP_OE_OUT |-> !DATA_PINS_OE_OUT) // RULE_10
    else $error("holder and driver both on");
endmodule // ebp_pin_ctrl

/* bench/ebp_mem_model.sv */
`timescale 1ns/1ps
module ebp_mem_model
(
  // Clock
  input wire logic clk_in,
  // Device pins
  input wire logic [15:0] addr_in,
  input wire logic addr_oe_in,
  input wire logic [15:0] dev_in,
  input wire logic dev_oe_in,
  input wire logic [15:0] keep_in,
  input wire logic keep_oe_in,
  // Host stand-in
  input wire logic [15:0] host_in,
  input wire logic host_oe_in,
  // Resolved data wire
  output logic [15:0] wire_out
);
  logic [15:0] mem_r [16];
  logic [15:0] last_r = 16'h0000;
  always_ff @(posedge clk_in)
  begin
    last_r <= wire_out;
    if (dev_oe_in && addr_oe_in)
      mem_r[addr_in[3:0]] <= dev_in;
  end
  // Memory answers while addressed; no direction pin, so the device wins
  always_comb
  begin
    if (dev_oe_in)
      wire_out = dev_in;
    else if (host_oe_in)
      wire_out = host_in;
    else if (addr_oe_in)
      wire_out = mem_r[addr_in[3:0]];
    else if (keep_oe_in)
      wire_out = keep_in;
    else
      wire_out = ~last_r;  // Floating line must not look like a kept level
  end
endmodule // ebp_mem_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
  import ebp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ebp_req_s req = '0;
  ebp_rsp_s rsp;
  ebp_host_s host = '0;
  logic wide = 1'b0;
  logic rpin_n = 1'b1;
  logic hold_n = 1'b1;
  logic off_n = 1'b1;
  logic h_oe = 1'b0;
  logic [15:0] h_a = 16'h0000;
  logic [15:0] h_d = 16'h0000;
  logic [15:0] h_addr, h_wdata, la_out, la_wire, d_out, k_out, d_wire;
  logic [6:0] ha_out;
  logic hack_n, la_oe, ha_oe, d_oe, k_oe;
  integer seed = 49822;
  integer n_errors = 0;
  integer checks = 0;
  integer cycles = 0;
  assign la_wire = la_oe ? la_out : h_a;

  ebp_pin_ctrl i_dut
  (
    .MCLK_IN(clk), .RESET_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CORE_REQ_IN(req), .CORE_RSP_OUT(rsp), .HOST_IN(host),
    .HOST_ADDR_OUT(h_addr), .HOST_WDATA_OUT(h_wdata),
    .HOST_WIDE_MODE_SELECT_IN(wide), .RESET_INPUT_N_IN(rpin_n), .HOLD_REQ_N_IN(hold_n),
    .OUTPUT_OFF_N_IN(off_n), .HOLD_ACK_N_OUT(hack_n),
    .LOW_ADDRESS_PINS_IN(la_wire), .LOW_ADDRESS_PINS_OUT(la_out), .LOW_ADDRESS_PINS_OE_OUT(la_oe),
    .HIGH_ADDRESS_PINS_OUT(ha_out), .HIGH_ADDRESS_PINS_OE_OUT(ha_oe),
    .DATA_PINS_IN(d_wire), .DATA_PINS_OUT(d_out), .DATA_PINS_OE_OUT(d_oe),
    .DATA_KEEP_OUT(k_out), .DATA_KEEP_OE_OUT(k_oe)
  );

  ebp_mem_model i_mem
  (
    .clk_in(clk), .addr_in(la_out), .addr_oe_in(la_oe), .dev_in(d_out), .dev_oe_in(d_oe),
    .keep_in(k_out), .keep_oe_in(k_oe), .host_in(h_d), .host_oe_in(h_oe), .wire_out(d_wire)
  );

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up;
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One core access; pins are checked every cycle until done
  task automatic core(input ebp_space_e sp, input logic wr, input logic [22:0] a,
                      input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge clk);
    req <= '{1'b1, sp, wr, a, wd};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (la_oe === 1'b1)
      begin
        chk("low addr", la_out, a[15:0]);
        chk("high oe", ha_oe, sp == SP_PROG);
        if (sp == SP_PROG)
          chk("high addr", ha_out, a[22:16]);
      end
      if (d_oe === 1'b1)
        chk("data out", d_out, wd);
      if (off_n === 1'b0)
        chk("off oe", {la_oe, ha_oe, d_oe}, 32'h0000_0000);
    end
    while (rsp.done !== 1'b1 && n < 40);
    chk("done", rsp.done, 32'h0000_0001);
    rd = rsp.rdata;
    req <= '0;
  endtask

  initial
  begin
    logic [31:0] rd;
    logic err;
    logic [15:0] d;
    logic [15:0] v;
    logic [22:0] a;
    ebp_space_e sp;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("ack idle", hack_n, 32'h0000_0001);
    chk("data oe", d_oe, 32'h0000_0000);
    apb(1'b0, OFS_BANK_SWITCH, 32'h0000_0000, rd, err);
    chk("bank reset", rd, BANK_SWITCH_RST);
    chk("bank err", err, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
    chk("unmapped", err, 32'h0000_0001);
    $display("test reset finished");
    for (int i = 0; i < 12; i++)
    begin
      sp = ebp_space_e'($unsigned($random(seed)) % 3);
      a = 23'($random(seed));
      d = 16'($random(seed));
      core(sp, 1'b1, a, d, v);
      core(sp, 1'b0, a, 16'($random(seed)), v);
      chk("read back", v, d);
    end
    $display("test traffic finished");
    apb(1'b1, OFS_BANK_SWITCH, 32'h0000_0001 << KEEP_EN_BIT, rd, err);
    d = 16'($random(seed));
    core(SP_DATA, 1'b1, 23'h00_0042, d, v);
    repeat (3) @(posedge clk);
    chk("keep oe", k_oe, 32'h0000_0001);
    chk("keep val", k_out, d);
    chk("pin level", d_wire, d);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
    chk("stat keeping", rd, 32'h0000_0001 << STAT_KEEPING_BIT);
    rpin_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("keep off", k_oe, 32'h0000_0000);
    chk("rst data oe", d_oe, 32'h0000_0000);
    rpin_n <= 1'b1;
    apb(1'b0, OFS_BANK_SWITCH, 32'h0000_0000, rd, err);
    chk("bank cleared", rd, 32'h0000_0000);
    $display("test keeper finished");
    hold_n <= 1'b0;
    req <= '{1'b1, SP_IO, 1'b1, 23'h00_1234, 16'h0F0F};
    repeat (10)
    begin
      @(posedge clk);
      chk("held done", rsp.done, 32'h0000_0000);
    end
    chk("hold ack", hack_n, 32'h0000_0000);
    chk("hold oe", {la_oe, ha_oe, d_oe}, 32'h0000_0000);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
    chk("stat hold", rd, 32'h0000_0001 << STAT_HOLD_ACK_BIT);
    hold_n <= 1'b1;
    core(SP_IO, 1'b1, 23'h00_1234, 16'h0F0F, v);
    $display("test hold finished");
    off_n <= 1'b0;
    core(SP_PROG, 1'b1, 23'h7F_00F0, 16'h3C3C, v);
    off_n <= 1'b1;
    $display("test output off finished");
    wide <= 1'b1;
    h_a <= 16'($random(seed));
    h_d <= 16'($random(seed));
    h_oe <= 1'b1;
    repeat (3) @(posedge clk);
    chk("host addr", h_addr, h_a);
    chk("addr oe", la_oe, 32'h0000_0000);
    chk("host wdata", h_wdata, h_d);
    apb(1'b0, OFS_STATUS, 32'h0000_0000, rd, err);
    chk("stat host", rd, 32'h0000_0001 << STAT_HOST_MODE_BIT);
    d = 16'($random(seed));
    h_oe <= 1'b0;
    host <= '{1'b1, d};
    repeat (3) @(posedge clk);
    chk("host rdata", {d_oe, d_out}, {15'h0000, 1'b1, d});
    host <= '0;
    wide <= 1'b0;
    repeat (3) @(posedge clk);
    chk("host release", d_oe, 32'h0000_0000);
    $display("test host finished");
    wrap_up;
  end
endmodule // tb
